//--- bench/dwpr_ctrl_test.sv
/*
  Self-checking bench for the strobe-driven DRAM controller.
  Assumes dwpr_pkg and the memory model are compiled before this file.
*/
`timescale 1ns/1ps

module dwpr_ctrl_test;
   // ====================
   // Bench signals.
   logic               clk       = 1'b0;
   logic               rstn      = 1'b0;
   logic               req_valid = 1'b0;
   dwpr_pkg::dwpr_op_t req_op    = dwpr_pkg::DWPR_OP_READ;
   logic [15:0]        req_addr  = 16'h0000;
   logic               req_wdata = 1'b0;
   logic               req_ready, rsp_valid, rsp_rdata, init_done;
   logic [7:0]         dram_addr;
   logic               dram_ras_n, dram_cas_n, dram_we_n, dram_d, dram_q;
   int                 failures   = 0;
   int                 num_checks = 0;
   int                 ras_falls  = 0;

   // ====================
   // Design and memory.
   dwpr_ctrl i_dwpr_ctrl (.clk(clk), .rstn(rstn), .req_valid(req_valid),
      .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
      .init_done(init_done), .dram_addr(dram_addr), .dram_ras_n(dram_ras_n),
      .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n), .dram_d(dram_d),
      .dram_q(dram_q));
   dwpr_dram_model #(.ACC_NS(90)) i_dwpr_dram_model (.addr(dram_addr), .d(dram_d),
      .ras_n(dram_ras_n), .cas_n(dram_cas_n), .we_n(dram_we_n), .q(dram_q));

   // Clock at 20 MHz and a count of row activations.
   always #25 clk = ~clk;
   always @(negedge dram_ras_n) ras_falls++;

   // ====================
   // Shared tasks.
   task automatic check(input bit ok, input string msg);
      num_checks++;
      if (!ok) begin
         failures++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One access, entered at a falling edge; waits for take and answer.
   task automatic access(input logic [1:0] op, input logic [15:0] a, input logic wd,
                         output logic rd);
      int n = 0;
      req_valid = 1'b1;
      req_op    = dwpr_pkg::dwpr_op_t'(op);
      req_addr  = a;
      req_wdata = wd;
      #1;
      while (req_ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         #1;
         n++;
      end
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      check(n < 40, "request not answered");
      rd = rsp_rdata;
   endtask

   // ====================
   // Scenarios.
   // A request held during start-up must wait for the wake cycles.
   task automatic t_init();
      bit early = 1'b0;
      int n = 0;
      req_valid = 1'b1;
      req_op    = dwpr_pkg::DWPR_OP_WRITE;
      while (init_done !== 1'b1 && n < 6000) begin
         @(negedge clk);
         if (req_ready === 1'b1 && init_done !== 1'b1) early = 1'b1;
         n++;
      end
      req_valid = 1'b0;
      @(negedge clk);
      check(!early && n < 6000, "request taken during start-up");
      check(i_dwpr_dram_model.wake >= 8, "too few wake cycles");
   endtask

   // Writes then reads across row and column boundaries, row top bit included.
   task automatic t_write_read();
      logic [15:0] a [6] = '{16'h0000, 16'h8000, 16'h00ff, 16'hff00, 16'h1234, 16'h3412};
      logic        v [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      logic        rd;
      for (int i = 0; i < 6; i++) access(2'h1, a[i], v[i], rd);
      for (int i = 0; i < 6; i++) begin
         access(2'h0, a[i], 1'b0, rd);
         check(rd === v[i], "read back differs");
      end
   endtask

   // Combined read and write return the old bit and store the new one.
   task automatic t_rmw();
      logic rd;
      access(2'h2, 16'h1234, 1'b0, rd);
      check(rd === 1'b1, "modify cycle old bit");
      access(2'h0, 16'h1234, 1'b1, rd);
      check(rd === 1'b0, "modify cycle new bit");
      access(2'h3, 16'h3412, 1'b1, rd);
      check(rd === 1'b0, "read while write old bit");
      access(2'h0, 16'h3412, 1'b0, rd);
      check(rd === 1'b1, "read while write new bit");
   endtask

   // A mix of kinds on one row, right after a refresh, uses one activation.
   task automatic t_page();
      logic [1:0] o [6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
      logic [7:0] c [6] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
      logic       w [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      logic       e [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      logic       rd;
      int         f;
      @(negedge dram_ras_n);
      @(posedge dram_ras_n);
      @(negedge clk);
      f = ras_falls;
      for (int i = 0; i < 6; i++) begin
         access(o[i], {8'h5a, c[i]}, w[i], rd);
         if (i >= 2) check(rd === e[i], "page access bit");
      end
      check(ras_falls - f == 1, "row reopened inside page");
   endtask

   // A long page burst must be split so the row is never held too long.
   task automatic t_long_page();
      logic rd;
      int   f = ras_falls;
      for (int i = 0; i < 60; i++) access(2'h0, {8'h5a, i[7:0]}, 1'b0, rd);
      check(ras_falls - f >= 2, "row held open too long");
   endtask

   // While idle, exactly one refresh per 312 cycles, all rows in turn.
   task automatic t_refresh();
      int f;
      @(negedge dram_ras_n);
      @(negedge clk);
      f = ras_falls;
      repeat (39936) @(negedge clk);
      check(ras_falls - f == 128, "refresh count per window");
      check(i_dwpr_dram_model.stale_rows(2000000.0) == 0, "row left stale");
   endtask

   // A reset in mid-run parks all strobes and drops the ready level.
   task automatic t_reset();
      rstn = 1'b0;
      @(negedge clk);
      check(dram_ras_n === 1'b1 && dram_cas_n === 1'b1 && dram_we_n === 1'b1
            && rsp_valid === 1'b0 && init_done === 1'b0, "outputs busy in reset");
      rstn = 1'b1;
   endtask

   // ====================
   // Main sequence and watchdog.
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      t_init();
      t_write_read();
      t_rmw();
      t_page();
      t_long_page();
      t_refresh();
      check(i_dwpr_dram_model.viol == 0, "memory timing broken");
      @(negedge clk);
      t_reset();
      print_verdict();
   end

   // Cuts a hang short well after the expected run of about 2.15 ms.
   initial begin
      #3000000;
      failures++;
      $display("BAD %0t watchdog expired", $time);
      print_verdict();
   end
endmodule

//--- bench/dwpr_dram_model.sv
/*
  Behavioural model of the 64K x 1 multiplexed-address dynamic RAM.
  Assumes its strobes, address and data come from the controller under test;
  it has no system clock and reacts to strobe edges only, apart from its free-running 37 ns churn toggle.
*/
`timescale 1ns/1ps

module dwpr_dram_model #(
   parameter int ACC_NS  = 40,
   parameter int LEAD_NS = 100
) (
   // Multiplexed address and data in.
   input  wire logic [7:0] addr,
   input  wire logic       d,
   // Strobes, active low.
   input  wire logic       ras_n,
   input  wire logic       cas_n,
   input  wire logic       we_n,
   // Data out.
   output logic            q
);
   // ====================
   // Storage and bookkeeping.
   logic       mem [65536];
   logic [7:0] row_l;
   logic [7:0] col_l;
   logic       rd_bit;
   logic       rd_on  = 1'b0;
   logic       acc_ok = 1'b0;
   logic       churn  = 1'b0;
   bit         ras_act;
   bit         we_seen;
   realtime    ras_t;
   realtime    we_t;
   realtime    last_ref [128];
   int         wake = 0;
   int         viol = 0;

   // A pin that is not driven churns, so a stale bit is never read by luck.
   always #37 churn = ~churn;
   assign q = (rd_on && acc_ok && !cas_n) ? rd_bit : churn;

   // Row strobe fall latches the row and refreshes it; refresh ignores the top bit.
   always @(negedge ras_n) begin
      if (wake == 0 && $realtime < 100000.0) viol++;
      ras_t = $realtime;
      ras_act = 1'b1;
      we_seen = 1'b0;
      // The address leaves on the same clock edge, so let it settle first.
      #1;
      row_l = addr;
      last_ref[addr[6:0]] = $realtime;
   end

   // Row strobe rise ends an activation; its length and write lead are checked.
   always @(posedge ras_n) begin
      if (ras_act) begin
         wake++;
         if ($realtime - ras_t > 10000.0) viol++;
         if (we_seen && $realtime - we_t < LEAD_NS) viol++;
      end
      ras_act = 1'b0;
   end

   // Column strobe fall latches the column; an early write stores the data bit.
   always @(negedge cas_n) begin
      if (wake < 8) viol++;
      // Address, write strobe and data leave on the same edge; let them settle.
      #1;
      col_l = addr;
      rd_bit = mem[{row_l, addr}];
      rd_on = we_n;
      acc_ok = 1'b0;
      acc_ok <= #(ACC_NS) 1'b1;
      if (!we_n) mem[{row_l, addr}] = d;
   end

   // Column strobe rise turns the output off and checks the column write lead.
   always @(posedge cas_n) begin
      if (we_seen && $realtime - we_t < LEAD_NS) viol++;
      rd_on = 1'b0;
   end

   // A write strobe that falls inside an open column stores the data bit then.
   always @(negedge we_n) begin
      we_t = $realtime;
      we_seen = 1'b1;
      // Column strobe and data may move on the same edge; let them settle.
      #1;
      if (!cas_n && !ras_n) mem[{row_l, col_l}] = d;
   end

   // Counts rows whose last refresh is older than the given span.
   function automatic int stale_rows(input realtime span);
      int n = 0;
      for (int r = 0; r < 128; r++) if ($realtime - last_ref[r] > span) n++;
      return n;
   endfunction
endmodule

//--- hdl/dwpr_consts.svh
/*
  Timing and layout constants for the strobe-driven DRAM controller.
  Assumes a 20 MHz system clock; all times are in nanoseconds.
*/
`ifndef DWPR_CONSTS_SVH
`define DWPR_CONSTS_SVH

// ==========================================================
// Clock, address layout and wake-up cycle count.
`define DWPR_CLK_NS          50
`define DWPR_ADDR_W          8
`define DWPR_REF_ROW_W       7
`define DWPR_WAKE_CYCLES     4'h8

// ==========================================================
// Strobe minimum times (nanoseconds), rounded up to cycles.
`define DWPR_ROW_TO_COL_NS   50
`define DWPR_COL_ACTIVE_NS   150
`define DWPR_COL_PRECHG_NS   100
`define DWPR_ROW_PRECHG_NS   150
`define DWPR_ROW_ACTIVE_NS   200
`define DWPR_WRITE_LEAD_NS   100
`define DWPR_COL_TO_WR_NS    50

// ==========================================================
// Long times: power-up pause, row active limit, refresh spacing.
`define DWPR_PWR_PAUSE_NS    100000
`define DWPR_ROW_MAX_NS      10000
`define DWPR_REF_PERIOD_NS   15600

`endif

//--- hdl/dwpr_ctrl.sv
/*
  Host-side controller for a 64K x 1 multiplexed-address dynamic RAM.
  Assumes the memory answers on dram_q within the column active time and
  that all inputs are synchronous to clk.
*/
`timescale 1ns/1ps
`include "dwpr_consts.svh"

module dwpr_ctrl #(
   parameter int PWR_PAUSE_NS = `DWPR_PWR_PAUSE_NS
) (
   // Clock and reset.
   input  wire logic              clk,
   input  wire logic              rstn,
   // User request side.
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire dwpr_pkg::dwpr_op_t req_op,
   input  wire logic [15:0]       req_addr,
   input  wire logic              req_wdata,
   // User answer side.
   output logic                   rsp_valid,
   output logic                   rsp_rdata,
   output logic                   init_done,
   // Memory pins.
   output logic [7:0]             dram_addr,
   output logic                   dram_ras_n,
   output logic                   dram_cas_n,
   output logic                   dram_we_n,
   output logic                   dram_d,
   input  wire logic              dram_q
);

   // ==========================================================
   // Cycle counts.

   // Least time rounded up to whole cycles, never below one.
   function automatic logic [11:0] cyc_up(input int ns);
      int c;
      c = (ns + `DWPR_CLK_NS - 1) / `DWPR_CLK_NS;
      if (c < 1) c = 1;
      return c[11:0];
   endfunction

   // Longest time rounded down to whole cycles, never below one.
   function automatic logic [11:0] cyc_dn(input int ns);
      int c;
      c = ns / `DWPR_CLK_NS;
      if (c < 1) c = 1;
      return c[11:0];
   endfunction

   localparam logic [11:0] RCD_CYC  = cyc_up(`DWPR_ROW_TO_COL_NS);
   localparam logic [11:0] CAS_CYC  = cyc_up(`DWPR_COL_ACTIVE_NS);
   localparam logic [11:0] CP_CYC   = cyc_up(`DWPR_COL_PRECHG_NS);
   localparam logic [11:0] RP_CYC   = cyc_up(`DWPR_ROW_PRECHG_NS);
   localparam logic [11:0] RAS_CYC  = cyc_up(`DWPR_ROW_ACTIVE_NS);
   localparam logic [11:0] WL_CYC   = cyc_up(`DWPR_WRITE_LEAD_NS);
   localparam logic [11:0] CWD_CYC  = cyc_up(`DWPR_COL_TO_WR_NS);
   localparam logic [11:0] PWR_CYC  = cyc_up(PWR_PAUSE_NS);
   localparam logic [11:0] RMAX_CYC = cyc_dn(`DWPR_ROW_MAX_NS);
   localparam logic [11:0] REF_CYC  = cyc_dn(`DWPR_REF_PERIOD_NS);
   // Row-active count below which one more page column still fits.
   localparam logic [11:0] PAGE_LIM = RMAX_CYC - CAS_CYC - WL_CYC - CP_CYC - 12'h004;

   dwpr_pkg::dwpr_regs_t r_reg, r_next;
   logic                 done;
   logic                 same_row;
   logic                 accept;

   // ==========================================================
   // Request handshake.

   // New accesses are taken when idle, or as a page column when the open
   // row matches and the row active limit leaves room.
   assign done     = (r_reg.cnt == 12'h000);
   assign same_row = (req_addr[15:8] == r_reg.row);
   always_comb begin
      req_ready = 1'b0;
      if (r_reg.state == dwpr_pkg::DWPR_IDLE) begin
         req_ready = !r_reg.ref_due;
      end else if (r_reg.state == dwpr_pkg::DWPR_CPRE) begin
         req_ready = done && !r_reg.ref_due && same_row &&
                     ({4'h0, r_reg.ras_cnt} < PAGE_LIM);
      end
   end
   assign accept = req_valid && req_ready;

   // ==========================================================
   // Next state.
   always_comb begin
      r_next           = r_reg;
      r_next.rsp_valid = 1'b0;
      r_next.cnt       = done ? 12'h000 : r_reg.cnt - 12'h001;
      // Row active time, used to bound page bursts.
      r_next.ras_cnt   = r_reg.ras_n ? 8'h00 :
                         (r_reg.ras_cnt == 8'hff ? 8'hff : r_reg.ras_cnt + 8'h01);
      // Refresh spacing; runs from reset so the part is never left idle.
      if (r_reg.ref_tmr == REF_CYC[9:0] - 10'h001) begin
         r_next.ref_tmr = 10'h000;
      end else begin
         r_next.ref_tmr = r_reg.ref_tmr + 10'h001;
      end
      // Latch a new access: row on the first one, column always.
      if (accept) begin
         r_next.op    = req_op;
         r_next.col   = req_addr[7:0];
         r_next.wdata = req_wdata;
      end
      case (r_reg.state)
         dwpr_pkg::DWPR_PWR: begin
            if (done) begin
               r_next.state = dwpr_pkg::DWPR_WACT;
               r_next.ras_n = 1'b0;
               r_next.cnt   = RAS_CYC - 12'h001;
            end
         end
         dwpr_pkg::DWPR_WACT: begin
            if (done) begin
               r_next.state    = dwpr_pkg::DWPR_WPRE;
               r_next.ras_n    = 1'b1;
               r_next.wake_cnt = r_reg.wake_cnt + 4'h1;
               r_next.cnt      = RP_CYC - 12'h001;
            end
         end
         dwpr_pkg::DWPR_WPRE: begin
            if (done) begin
               if (r_reg.wake_cnt == `DWPR_WAKE_CYCLES) begin
                  r_next.state = dwpr_pkg::DWPR_IDLE;
               end else begin
                  r_next.state = dwpr_pkg::DWPR_WACT;
                  r_next.ras_n = 1'b0;
                  r_next.cnt   = RAS_CYC - 12'h001;
               end
            end
         end
         dwpr_pkg::DWPR_IDLE: begin
            if (r_reg.ref_due) begin
               // Row-only refresh: column strobe stays high.
               r_next.state   = dwpr_pkg::DWPR_REF;
               r_next.addr    = {1'b0, r_reg.ref_row};
               r_next.ras_n   = 1'b0;
               r_next.ref_due = 1'b0;
               r_next.cnt     = RAS_CYC - 12'h001;
            end else if (accept) begin
               r_next.state = dwpr_pkg::DWPR_ROW;
               r_next.row   = req_addr[15:8];
               r_next.addr  = req_addr[15:8];
               r_next.ras_n = 1'b0;
               r_next.cnt   = RCD_CYC - 12'h001;
            end
         end
         dwpr_pkg::DWPR_ROW, dwpr_pkg::DWPR_CPRE: begin
            if (r_reg.state == dwpr_pkg::DWPR_CPRE && done && !accept) begin
               r_next.state = dwpr_pkg::DWPR_RPRE;
               r_next.ras_n = 1'b1;
               r_next.cnt   = RP_CYC - 12'h001;
            end else if (done) begin
               // Column address goes out with the column strobe; plain writes are
               // always early so the data output never drives for them.
               r_next.state = dwpr_pkg::DWPR_COL;
               r_next.addr  = accept ? req_addr[7:0] : r_reg.col;
               r_next.cas_n = 1'b0;
               r_next.we_n  = !((accept ? req_op : r_reg.op) == dwpr_pkg::DWPR_OP_WRITE);
               r_next.dout  = accept ? req_wdata : r_reg.wdata;
               r_next.wr_ph = 1'b0;
               r_next.cnt   = CAS_CYC - 12'h001;
            end
         end
         dwpr_pkg::DWPR_COL: begin
            // Read-while-write: write strobe after the column-to-write delay.
            if (!r_reg.wr_ph && r_reg.op == dwpr_pkg::DWPR_OP_RWW &&
                r_reg.cnt == CAS_CYC - CWD_CYC) begin
               r_next.we_n = 1'b0;
               r_next.dout = r_reg.wdata;
            end
            if (done) begin
               if (!r_reg.wr_ph) begin
                  r_next.rdata = dram_q;
               end
               if (!r_reg.wr_ph && r_reg.op == dwpr_pkg::DWPR_OP_RMW) begin
                  // Read data is in hand; now write with a full lead time.
                  r_next.we_n  = 1'b0;
                  r_next.dout  = r_reg.wdata;
                  r_next.wr_ph = 1'b1;
                  r_next.cnt   = WL_CYC - 12'h001;
               end else begin
                  r_next.state     = dwpr_pkg::DWPR_CPRE;
                  r_next.cas_n     = 1'b1;
                  r_next.we_n      = 1'b1;
                  r_next.rsp_valid = 1'b1;
                  r_next.cnt       = CP_CYC - 12'h001;
               end
            end
         end
         dwpr_pkg::DWPR_RPRE: begin
            if (done) begin
               r_next.state = dwpr_pkg::DWPR_IDLE;
            end
         end
         dwpr_pkg::DWPR_REF: begin
            if (done) begin
               r_next.state   = dwpr_pkg::DWPR_RPRE;
               r_next.ras_n   = 1'b1;
               r_next.ref_row = r_reg.ref_row + 7'h01;
               r_next.cnt     = RP_CYC - 12'h001;
            end
         end
         default: begin
            r_next.state = dwpr_pkg::DWPR_IDLE;
            r_next.ras_n = 1'b1;
            r_next.cas_n = 1'b1;
            r_next.we_n  = 1'b1;
         end
      endcase
      // A refresh tick wins over the clear when they meet.
      if (r_reg.ref_tmr == REF_CYC[9:0] - 10'h001) begin
         r_next.ref_due = 1'b1;
      end
   end

   // ==========================================================
   // State register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r_reg          <= '0;
         r_reg.state    <= dwpr_pkg::DWPR_PWR;
         r_reg.cnt      <= PWR_CYC;
         r_reg.ras_n    <= 1'b1;
         r_reg.cas_n    <= 1'b1;
         r_reg.we_n     <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // Flag set at the first edge after reset; reset itself loads the power-up pause.
   logic pwr_loaded_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pwr_loaded_reg <= 1'b0;
      end else begin
         pwr_loaded_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Outputs, all from flip-flops except init_done, decoded from the state.
   assign dram_addr  = r_reg.addr;
   assign dram_ras_n = r_reg.ras_n;
   assign dram_cas_n = r_reg.cas_n;
   assign dram_we_n  = r_reg.we_n;
   assign dram_d     = r_reg.dout;
   assign rsp_valid  = r_reg.rsp_valid;
   assign rsp_rdata  = r_reg.rdata;
   assign init_done  = !(r_reg.state inside {dwpr_pkg::DWPR_PWR, dwpr_pkg::DWPR_WACT,
                                            dwpr_pkg::DWPR_WPRE});

   // ==========================================================
   // Checks.

   // Cycle count of continuous row strobe activity.
   logic [11:0] ras_low_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ras_low_reg <= 12'h000;
      end else begin
         ras_low_reg <= dram_ras_n ? 12'h000 : ras_low_reg + 12'h001;
      end
   end

   ras_max_a: assert property (@(posedge clk) disable iff (!rstn)
      ras_low_reg <= RMAX_CYC)
      else $error("row strobe held low too long");

   early_wr_a: assert property (@(posedge clk) disable iff (!rstn)
      ($fell(dram_cas_n) && r_reg.op == dwpr_pkg::DWPR_OP_WRITE) |-> !dram_we_n)
      else $error("write strobe late for early write");

   wr_lead_a: assert property (@(posedge clk) disable iff (!rstn)
      $fell(dram_we_n) |-> (!dram_cas_n && !dram_ras_n) [*2])
      else $error("write lead time broken");

   rmw_order_a: assert property (@(posedge clk) disable iff (!rstn)
      ($fell(dram_we_n) && r_reg.op == dwpr_pkg::DWPR_OP_RMW) |->
      $past(dram_cas_n, 4) && !$past(dram_cas_n, 3) && !$past(dram_cas_n, 1))
      else $error("write strobe before read data");

   rww_delay_a: assert property (@(posedge clk) disable iff (!rstn)
      ($fell(dram_we_n) && r_reg.op == dwpr_pkg::DWPR_OP_RWW) |->
      !$past(dram_cas_n, 1) && $past(dram_cas_n, 2))
      else $error("write strobe wrong in read-while-write");

   ref_cas_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.state == dwpr_pkg::DWPR_REF) |-> dram_cas_n && !dram_ras_n && !dram_addr[7])
      else $error("column strobe active during refresh");

   ref_next_a: assert property (@(posedge clk) disable iff (!rstn)
      ($past(r_reg.state) == dwpr_pkg::DWPR_REF && $rose(dram_ras_n)) |->
      r_reg.ref_row == $past(r_reg.ref_row) + 7'h01)
      else $error("refresh row did not advance");

   ref_due_a: assert property (@(posedge clk) disable iff (!rstn)
      (r_reg.ref_tmr == 10'h000 && $past(r_reg.ref_tmr) != 10'h000) |-> r_reg.ref_due)
      else $error("refresh tick lost");

   wake_cnt_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(init_done) |-> r_reg.wake_cnt == 4'h8)
      else $error("fewer than eight wake cycles");

   row_pre_a: assert property (@(posedge clk) disable iff (!rstn)
      ($rose(dram_ras_n) && pwr_loaded_reg) |-> dram_ras_n [*3])
      else $error("row precharge too short");

endmodule

//--- hdl/dwpr_pkg.sv
/*
  Types for the strobe-driven DRAM controller.
  Assumes dwpr_consts.svh is included by the files that use it.
*/
package dwpr_pkg;

   // Access kinds requested by the user side.
   typedef enum logic [1:0] {
      DWPR_OP_READ  = 2'h0,
      DWPR_OP_WRITE = 2'h1,
      DWPR_OP_RMW   = 2'h2,
      DWPR_OP_RWW   = 2'h3
   } dwpr_op_t;

   // Sequencer states, one-hot.
   typedef enum logic [8:0] {
      DWPR_PWR  = 9'h001,
      DWPR_WACT = 9'h002,
      DWPR_WPRE = 9'h004,
      DWPR_IDLE = 9'h008,
      DWPR_ROW  = 9'h010,
      DWPR_COL  = 9'h020,
      DWPR_CPRE = 9'h040,
      DWPR_RPRE = 9'h080,
      DWPR_REF  = 9'h100
   } dwpr_state_t;

   // Whole controller state.
   typedef struct packed {
      dwpr_state_t state;
      logic [11:0] cnt;
      logic [7:0]  ras_cnt;
      logic [3:0]  wake_cnt;
      logic [9:0]  ref_tmr;
      logic        ref_due;
      logic [6:0]  ref_row;
      logic [7:0]  row;
      logic [7:0]  col;
      dwpr_op_t    op;
      logic        wdata;
      logic        wr_ph;
      logic [7:0]  addr;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic        dout;
      logic        rdata;
      logic        rsp_valid;
   } dwpr_regs_t;

endpackage
